/* src/sensor_cfg_pkg.sv */
package sensor_cfg_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MIN_RES    = 8'h03;
  localparam logic [7:0] OFS_CONV_SETUP = 8'h04;
  localparam logic [7:0] OFS_CNT_CLOCK  = 8'h05;
  localparam logic [7:0] OFS_THR_LO     = 8'h06;
  localparam logic [7:0] OFS_THR_HI     = 8'h07;
  localparam logic [7:0] OFS_RO_FIRST   = 8'h01;
  localparam logic [7:0] OFS_RO_LAST    = 8'h05;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_MIN_RES    = 8'h45;
  localparam logic [7:0]  RST_CONV_SETUP = 8'h1b;
  localparam logic [7:0]  RST_CNT_CLOCK  = 8'h01;
  localparam logic [7:0]  RST_THR_BYTE   = 8'hff;
  localparam logic [15:0] RST_THR        = 16'hffff;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AMP_LSB      = 3;
  localparam int AMP_MSB      = 4;
  localparam int RESP_LSB     = 0;
  localparam int RESP_MSB     = 2;
  localparam int CLK_SEL_BIT  = 1;
  localparam int PD_BIT       = 0;
  localparam logic [7:0] CONV_SETUP_MASK = 8'h1f;
  localparam logic [7:0] CNT_CLOCK_MASK  = 8'h03;

  typedef enum logic [1:0] {
    AMP_1V,
    AMP_2V,
    AMP_4V,
    AMP_RSVD
  } amplitude_e;

  // Settings passed to the sensing logic
  typedef struct packed {
    logic [7:0]  min_resonance;
    amplitude_e  amplitude;
    logic [2:0]  response_time;
    logic        use_crystal;
    logic        timebase_power_down;
    logic [15:0] upper_threshold;
  } sense_cfg_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage

/* src/threshold_pair.sv */
`timescale 1ns/1ps
// Two-byte threshold with low-byte holding buffer; high-byte write commits both
module threshold_pair (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Byte writes
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // Active value
  output logic      [15:0] active
);
  import sensor_cfg_pkg::*;

  logic [7:0]  hold_q;
  logic [7:0]  hold_d;
  logic [15:0] active_q;
  logic [15:0] active_d;

  assign hold_d   = wr_low ? wdata : hold_q;             // R9
  assign active_d = wr_high ? {wdata, hold_q} : active_q; // R11
  assign active   = active_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_q   <= RST_THR_BYTE;                           // R14
      active_q <= RST_THR;                                // R14
    end else begin
      hold_q   <= hold_d;
      active_q <= active_d;
    end
  end
endmodule

/* src/sensor_cfg_regs.sv */
`timescale 1ns/1ps
// Contract
// R1: 0x03 holds minimum resonance code
// R2: Host computes code from log formula
// R3: Resonance code resets to 0x45
// R4: Setup bits 4:3 pick amplitude
// R5: Setup bits 2:0 response; reset 0x1b
// R6: Clock bit 1 selects crystal reference
// R7: Clock bit 0 powers timebase down
// R8: Clock register resets to 0x01
// R9: Write 0x06 loads holding buffer only
// R10: Read 0x06 returns active low byte
// R11: Write 0x07 commits whole threshold
// R12: Read 0x07 returns active high byte
// R13: Host writes 0x06 before 0x07
// R14: Threshold resets to all ones
// R15: Active conversion locks 0x01 to 0x05
// R16: Reserved bits read zero
module sensor_cfg_regs (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  // Register port
  input  wire sensor_cfg_pkg::reg_req_s   req,
  output logic                      [7:0] rdata,
  // Conversion state from power control
  input  wire logic                       active_conversion_bit,
  // Settings to the sensing logic
  output sensor_cfg_pkg::sense_cfg_s      cfg
);
  import sensor_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic       locked;
  logic       wr_min_res;
  logic       wr_conv;
  logic       wr_clock;
  logic       wr_thr_lo;
  logic       wr_thr_hi;
  logic [7:0] min_res_q;
  logic [7:0] conv_q;
  logic [7:0] clock_q;
  logic [15:0] thr_active;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  sense_cfg_s cfg_d;
  sense_cfg_s cfg_q;

  function automatic logic hit(input reg_req_s r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  assign locked     = active_conversion_bit &&
                      (req.addr >= OFS_RO_FIRST) && (req.addr <= OFS_RO_LAST); // R15
  assign wr_min_res = hit(req, OFS_MIN_RES) && !locked;
  assign wr_conv    = hit(req, OFS_CONV_SETUP) && !locked;
  assign wr_clock   = hit(req, OFS_CNT_CLOCK) && !locked;
  assign wr_thr_lo  = hit(req, OFS_THR_LO);
  assign wr_thr_hi  = hit(req, OFS_THR_HI);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      min_res_q <= RST_MIN_RES;    // R3
      conv_q    <= RST_CONV_SETUP; // R5
      clock_q   <= RST_CNT_CLOCK;  // R8
    end else begin
      if (wr_min_res) begin
        min_res_q <= req.wdata;    // R1
      end
      if (wr_conv) begin
        conv_q <= req.wdata & CONV_SETUP_MASK; // R16
      end
      if (wr_clock) begin
        clock_q <= req.wdata & CNT_CLOCK_MASK; // R16
      end
    end
  end

  threshold_pair u_thr (
    .mclk    (mclk),
    .resetn  (resetn),
    .wr_low  (wr_thr_lo),
    .wr_high (wr_thr_hi),
    .wdata   (req.wdata),
    .active  (thr_active)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  assign rdata_d = !req.rd                  ? 8'h00 :
                   (req.addr == OFS_MIN_RES)    ? min_res_q :
                   (req.addr == OFS_CONV_SETUP) ? conv_q :
                   (req.addr == OFS_CNT_CLOCK)  ? clock_q :
                   (req.addr == OFS_THR_LO)     ? thr_active[7:0] :  // R10
                   (req.addr == OFS_THR_HI)     ? thr_active[15:8] : // R12
                   8'h00;

  // ---------------------------------------------------------------
  // Settings out
  // ---------------------------------------------------------------
  assign cfg_d.min_resonance       = min_res_q;                          // R1
  assign cfg_d.amplitude           = amplitude_e'(conv_q[AMP_MSB:AMP_LSB]); // R4
  assign cfg_d.response_time       = conv_q[RESP_MSB:RESP_LSB];          // R5
  assign cfg_d.use_crystal         = clock_q[CLK_SEL_BIT];               // R6
  assign cfg_d.timebase_power_down = clock_q[PD_BIT];                    // R7
  assign cfg_d.upper_threshold     = thr_active;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      cfg_q   <= '{min_resonance: RST_MIN_RES,
                   amplitude: amplitude_e'(RST_CONV_SETUP[AMP_MSB:AMP_LSB]),
                   response_time: RST_CONV_SETUP[RESP_MSB:RESP_LSB],
                   use_crystal: RST_CNT_CLOCK[CLK_SEL_BIT],
                   timebase_power_down: RST_CNT_CLOCK[PD_BIT],
                   upper_threshold: RST_THR};
    end else begin
      rdata_q <= rdata_d;
      cfg_q   <= cfg_d;
    end
  end

  assign rdata = rdata_q;
  assign cfg   = cfg_q;
endmodule

/* test/host_model.sv */
`timescale 1ns/1ps
module host_model (
  // Clock and read data
  input  wire logic                     mclk,
  input  wire logic               [7:0] rdata,
  // Register port
  output sensor_cfg_pkg::reg_req_s      req
);
  import sensor_cfg_pkg::*;
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic thr(input logic [15:0] v);
    wr(8'h06, v[7:0]);
    wr(8'h07, v[15:8]);
  endtask
endmodule

/* test/sensor_cfg_regs_chk.sv */
`timescale 1ns/1ps
module sensor_cfg_regs_chk (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       resetn,
  // Register port
  input wire sensor_cfg_pkg::reg_req_s   req,
  input wire logic                 [7:0] rdata,
  // Lock and settings
  input wire logic                       active_conversion_bit,
  input wire sensor_cfg_pkg::sense_cfg_s cfg
);
  import sensor_cfg_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_lo_write;
    req.wr && req.addr == 8'h06;
  endsequence
  AST_RD_IDLE: assert property (!req.rd |=> rdata == 8'h00) else $error("rdata not zero");
  AST_RD_MIN: assert property (req.rd && req.addr == 8'h03 |=> rdata == cfg.min_resonance) else $error("min");
  AST_RD_SETUP: assert property (req.rd && req.addr == 8'h04 |=>
    rdata == {3'h0, cfg.amplitude, cfg.response_time}) else $error("setup");
  AST_RD_CLK: assert property (req.rd && req.addr == 8'h05 |=>
    rdata == {6'h0, cfg.use_crystal, cfg.timebase_power_down}) else $error("clock");
  AST_THR_BUF: assert property (s_lo_write |=> ##1 $stable(cfg.upper_threshold)) else $error("buffer");
  AST_RD_LO: assert property (req.rd && req.addr == 8'h06 |=> rdata == cfg.upper_threshold[7:0]) else $error("lo");
  AST_COMMIT: assert property (req.wr && req.addr == 8'h07 |=> ##1
    cfg.upper_threshold[15:8] == $past(req.wdata, 2)) else $error("commit");
  AST_RD_HI: assert property (req.rd && req.addr == 8'h07 |=> rdata == cfg.upper_threshold[15:8]) else $error("hi");
  AST_LOCK: assert property (active_conversion_bit && req.wr && req.addr == 8'h03 |=> ##1
    $stable(cfg.min_resonance)) else $error("lock");
endmodule
bind sensor_cfg_regs sensor_cfg_regs_chk chk_i (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
  .active_conversion_bit(active_conversion_bit), .cfg(cfg));

/* test/sensor_cfg_regs_tb_top.sv */
`timescale 1ns/1ps
module sensor_cfg_regs_tb_top;
  import sensor_cfg_pkg::*;
  logic       mclk;
  logic       resetn;
  logic       active_conversion_bit;
  logic [7:0] rdata;
  logic [7:0] d;
  reg_req_s   req;
  sense_cfg_s cfg;
  int         bad_count;
  int         n_checks;
  logic [7:0] rst_tab [5] = '{8'h45, 8'h1b, 8'h01, 8'hff, 8'hff};
  host_model host (.mclk(mclk), .rdata(rdata), .req(req));
  sensor_cfg_regs dut (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
    .active_conversion_bit(active_conversion_bit), .cfg(cfg));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    active_conversion_bit = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(8'(i + 3), rst_tab[i]);
    chk({7'h0, cfg.timebase_power_down}, 8'h01);
    host.wr(8'h03, 8'hb3);
    rchk(8'h03, 8'hb3);
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h04, {3'h7, i[1:0], i[2:0]});
      rchk(8'h04, {3'h0, i[1:0], i[2:0]});
      chk({3'h0, cfg.amplitude, cfg.response_time}, {3'h0, i[1:0], i[2:0]});
    end
    host.wr(8'h05, 8'hfe);
    rchk(8'h05, 8'h02);
    chk({6'h0, cfg.use_crystal, cfg.timebase_power_down}, 8'h02);
    host.wr(8'h06, 8'h34);
    rchk(8'h06, 8'hff);
    host.wr(8'h07, 8'h12);
    rchk(8'h06, 8'h34);
    rchk(8'h07, 8'h12);
    host.wr(8'h07, 8'h56);
    @(posedge mclk);
    #1;
    chk(cfg.upper_threshold[15:8], 8'h56);
    chk(cfg.upper_threshold[7:0], 8'h34);
    @(posedge mclk);
    active_conversion_bit <= 1'b1;
    host.wr(8'h03, 8'h00);
    rchk(8'h03, 8'hb3);
    host.wr(8'h05, 8'h01);
    rchk(8'h05, 8'h02);
    host.thr(16'h8877);
    rchk(8'h07, 8'h88);
    @(posedge mclk);
    active_conversion_bit <= 1'b0;
    rchk(8'h40, 8'h00);
    give_verdict();
  end
endmodule
